// ===== hdl/camera_settings_store.sv
// Functional notes
// - fifteen non-volatile user channels, each holding a full settings copy
// - selector takes factory or 1..15; factory loads only; resets to factory
// - load command copies the selected channel into the active settings
// - store command copies active settings into the selected channel
// - volatile store command keeps the copy in memory lost at power-off
// - commands are write-only; selector and power-up choice read back
// - start-up loads the power-up channel; choice is reloaded from the shared store
// - power-up choice becomes non-volatile only through a store command
// - defect and sequence settings live in one shared store
// - saveable set covers the eight active settings words
// - tone table entries belong to no channel; its enable is saved
// - tone table maps 10-bit levels, 0..1023, disabled at reset
`timescale 1ns/1ps
`default_nettype none
module camera_settings_store (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [9:0] pix_i,
  output logic [9:0] pix_o,
  output logic tone_table_enable_o,
  output logic defect_fix_enable_o,
  output logic seq_capture_enable_o,
  output logic [3:0] seq_capture_length_o,
  output logic busy_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  store_port_if sp ();

  logic [settings_pkg::SEL_W-1:0] settings_channel_select_q;
  logic [settings_pkg::SEL_W-1:0] powerup_channel_choice_q;
  logic [settings_pkg::TONE_W-1:0] tone_table_index_q;
  logic [settings_pkg::WORD_W-1:0] active_q [0:settings_pkg::SET_WORDS-1];
  logic [settings_pkg::WORD_W-1:0] shared_ctrl_q;
  logic [settings_pkg::WORD_W-1:0] seq_capture_slot_q;
  settings_pkg::state_t state_q;
  settings_pkg::then_t then_q;
  logic [settings_pkg::CH_W-1:0] ch_q;
  logic [settings_pkg::WIDX_W-1:0] word_q;
  logic [settings_pkg::WIDX_W-1:0] last_q;
  logic vol_q;
  logic boot_q;
  logic refused_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] readdata_q;
  logic [9:0] tone_rdata;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire busy = (state_q != settings_pkg::ST_IDLE) || boot_q;
  wire req = (avs_read_i || avs_write_i) && !ack_q;
  // any write waits while a transfer runs, so settings never change mid-copy
  wire take = req && !(avs_write_i && busy);
  wire wr_go = take && avs_write_i;
  wire [7:0] adr = {avs_address_i[7:2], 2'b00};
  wire in_set = (adr[7:5] == settings_pkg::OFS_SETTINGS[7:5]);
  wire [settings_pkg::WIDX_W-1:0] set_idx = adr[4:2];
  wire cmd_load = wr_go && (adr == settings_pkg::OFS_LOAD_CMD);
  wire cmd_store = wr_go && (adr == settings_pkg::OFS_STORE_CMD);
  wire cmd_vstore = wr_go && (adr == settings_pkg::OFS_VSTORE_CMD);
  wire sel_factory = (settings_channel_select_q == settings_pkg::SEL_RESET);
  wire [31:0] status_word = {30'h0000_0000, refused_q, busy};
  wire [31:0] wr_merge_set = settings_pkg::merge_be(active_q[set_idx], avs_writedata_i, avs_byteenable_i);
  wire [31:0] wr_merge_sh = settings_pkg::merge_be(shared_ctrl_q, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wr_merge_sl = settings_pkg::merge_be(seq_capture_slot_q, avs_writedata_i, avs_byteenable_i);

  // command offsets read as zero; unmapped offsets too
  wire [31:0] rd_mux =
    (adr == settings_pkg::OFS_CHANNEL_SELECT) ? {28'h000_0000, settings_channel_select_q} :
    (adr == settings_pkg::OFS_POWERUP_CHOICE) ? {28'h000_0000, powerup_channel_choice_q} :
    (adr == settings_pkg::OFS_STATUS) ? status_word :
    (adr == settings_pkg::OFS_TONE_INDEX) ? {22'h00_0000, tone_table_index_q} :
    (adr == settings_pkg::OFS_TONE_ENTRY) ? {22'h00_0000, tone_rdata} :
    (adr == settings_pkg::OFS_SHARED_CTRL) ? shared_ctrl_q :
    (adr == settings_pkg::OFS_SEQ_SLOTS) ? seq_capture_slot_q :
    in_set ? active_q[set_idx] : 32'h0000_0000;

  // one cycle of waitrequest low after the request is taken
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      wait_q <= !take;
      if (take && avs_read_i) begin
        readdata_q <= rd_mux;
      end
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = readdata_q;

  // ****************************************************************
  // software-visible controls
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      settings_channel_select_q <= settings_pkg::SEL_RESET;
      tone_table_index_q <= settings_pkg::TONE_INDEX_RESET;
    end else if (wr_go && avs_byteenable_i[0]) begin
      if (adr == settings_pkg::OFS_CHANNEL_SELECT) begin
        settings_channel_select_q <= avs_writedata_i[3:0];
      end
      if (adr == settings_pkg::OFS_TONE_INDEX) begin
        tone_table_index_q[7:0] <= avs_writedata_i[7:0];
      end
    end
    if (!rst_i && wr_go && avs_byteenable_i[1] && adr == settings_pkg::OFS_TONE_INDEX) begin
      tone_table_index_q[9:8] <= avs_writedata_i[9:8];
    end
  end

  wire tone_wr = wr_go && (adr == settings_pkg::OFS_TONE_ENTRY) && (&avs_byteenable_i[1:0]);

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  wire rd_step = (state_q == settings_pkg::ST_RD_DATA);
  wire wr_step = (state_q == settings_pkg::ST_WR);
  wire at_last = (word_q == last_q);
  wire to_shared = (ch_q == settings_pkg::SHARED_CH);

  assign sp.ch = ch_q;
  assign sp.word = word_q;
  assign sp.wr = wr_step;
  assign sp.vol = vol_q;
  assign sp.wdata = !to_shared ? active_q[word_q] :
                    (word_q == settings_pkg::SHW_DEFECT_SEQ) ? shared_ctrl_q :
                    (word_q == settings_pkg::SHW_SLOTS) ? seq_capture_slot_q :
                    (word_q == settings_pkg::SHW_POWERUP) ? {28'h000_0000, powerup_channel_choice_q} :
                    32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= settings_pkg::ST_IDLE;
      then_q <= settings_pkg::THEN_NONE;
      ch_q <= settings_pkg::FACTORY_CH;
      word_q <= '0;
      last_q <= '0;
      vol_q <= 1'b0;
      boot_q <= 1'b1;
      refused_q <= 1'b0;
    end else begin
      unique case (state_q)
        settings_pkg::ST_IDLE: begin
          word_q <= '0;
          if (boot_q) begin
            boot_q <= 1'b0;
            ch_q <= settings_pkg::SHARED_CH;
            last_q <= settings_pkg::SHW_POWERUP;
            then_q <= settings_pkg::THEN_BOOT_LOAD;
            state_q <= settings_pkg::ST_RD_ADDR;
          end else if (cmd_load) begin
            refused_q <= 1'b0;
            ch_q <= {1'b0, settings_channel_select_q};
            last_q <= settings_pkg::LAST_WORD;
            then_q <= settings_pkg::THEN_NONE;
            state_q <= settings_pkg::ST_RD_ADDR;
          end else if ((cmd_store || cmd_vstore) && sel_factory) begin
            refused_q <= 1'b1;
          end else if (cmd_store || cmd_vstore) begin
            refused_q <= 1'b0;
            ch_q <= {1'b0, settings_channel_select_q};
            vol_q <= cmd_vstore;
            last_q <= settings_pkg::LAST_WORD;
            then_q <= cmd_store ? settings_pkg::THEN_SHARED : settings_pkg::THEN_NONE;
            state_q <= settings_pkg::ST_WR;
          end
        end
        settings_pkg::ST_RD_ADDR: begin
          state_q <= settings_pkg::ST_RD_DATA;
        end
        settings_pkg::ST_RD_DATA: begin
          if (!at_last) begin
            word_q <= word_q + 3'h1;
            state_q <= settings_pkg::ST_RD_ADDR;
          end else if (then_q == settings_pkg::THEN_BOOT_LOAD) begin
            ch_q <= {1'b0, sp.rdata[3:0]};
            word_q <= '0;
            last_q <= settings_pkg::LAST_WORD;
            then_q <= settings_pkg::THEN_NONE;
            state_q <= settings_pkg::ST_RD_ADDR;
          end else begin
            state_q <= settings_pkg::ST_IDLE;
          end
        end
        settings_pkg::ST_WR: begin
          if (!at_last) begin
            word_q <= word_q + 3'h1;
          end else if (then_q == settings_pkg::THEN_SHARED) begin
            ch_q <= settings_pkg::SHARED_CH;
            vol_q <= 1'b0;
            word_q <= '0;
            last_q <= settings_pkg::SHW_POWERUP;
            then_q <= settings_pkg::THEN_NONE;
          end else begin
            state_q <= settings_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // active settings and shared store
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < settings_pkg::SET_WORDS; i++) begin
        active_q[i] <= settings_pkg::factory_word(3'(i));
      end
    end else if (rd_step && !to_shared) begin
      active_q[word_q] <= sp.rdata;
    end else if (wr_go && in_set) begin
      active_q[set_idx] <= wr_merge_set;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shared_ctrl_q <= settings_pkg::WORD_RESET;
      seq_capture_slot_q <= settings_pkg::WORD_RESET;
      powerup_channel_choice_q <= settings_pkg::SEL_RESET;
    end else if (rd_step && to_shared) begin
      if (word_q == settings_pkg::SHW_DEFECT_SEQ) begin
        shared_ctrl_q <= sp.rdata;
      end
      if (word_q == settings_pkg::SHW_SLOTS) begin
        seq_capture_slot_q <= sp.rdata;
      end
      if (word_q == settings_pkg::SHW_POWERUP) begin
        powerup_channel_choice_q <= sp.rdata[3:0];
      end
    end else if (wr_go) begin
      if (adr == settings_pkg::OFS_SHARED_CTRL) begin
        shared_ctrl_q <= wr_merge_sh;
      end
      if (adr == settings_pkg::OFS_SEQ_SLOTS) begin
        seq_capture_slot_q <= wr_merge_sl;
      end
      if (adr == settings_pkg::OFS_POWERUP_CHOICE && avs_byteenable_i[0]) begin
        powerup_channel_choice_q <= avs_writedata_i[3:0];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tone_table_enable_o <= 1'b0;
      defect_fix_enable_o <= 1'b0;
      seq_capture_enable_o <= 1'b0;
      seq_capture_length_o <= 4'h0;
      busy_o <= 1'b1;
    end else begin
      tone_table_enable_o <= active_q[settings_pkg::TONE_EN_WORD][settings_pkg::TONE_EN_BIT];
      defect_fix_enable_o <= shared_ctrl_q[settings_pkg::DEFECT_BIT];
      seq_capture_enable_o <= shared_ctrl_q[settings_pkg::SEQ_EN_BIT];
      seq_capture_length_o <= shared_ctrl_q[settings_pkg::SEQ_LEN_LSB +: settings_pkg::SEQ_LEN_W];
      busy_o <= busy;
    end
  end

  // ****************************************************************
  // submodules
  // ****************************************************************
  channel_store u_store (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sp(sp)
  );

  tone_table u_tone (
    .core_clk_i(core_clk_i),
    .enable_i(tone_table_enable_o),
    .index_i(tone_table_index_q),
    .wr_i(tone_wr),
    .wdata_i(avs_writedata_i[9:0]),
    .rdata_o(tone_rdata),
    .pix_i(pix_i),
    .pix_o(pix_o)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_NO_FACTORY_WRITE: assert property (sp.wr |-> sp.ch != settings_pkg::FACTORY_CH)
    else $error("write to factory channel");
  AST_STORE_TARGET: assert property ($rose(wr_step) && !vol_q |-> ch_q == {1'b0, $past(settings_channel_select_q)})
    else $error("store went to wrong channel");
  AST_LOAD_SOURCE: assert property (cmd_load && !busy |=> state_q == settings_pkg::ST_RD_ADDR
                                    && ch_q == {1'b0, $past(settings_channel_select_q)})
    else $error("load did not start from selected channel");
  AST_VOL_NO_NV: assert property (cmd_vstore && !busy && !sel_factory |=> vol_q ##1 (vol_q && sp.wr)[*7])
    else $error("volatile store touched non-volatile path");
  AST_CMD_STALL: assert property (req && avs_write_i && busy |=> avs_waitrequest_o)
    else $error("write accepted while busy");
  AST_CMD_READ_ZERO: assert property (take && avs_read_i && adr == settings_pkg::OFS_LOAD_CMD
                                      |=> avs_readdata_o == 32'h0000_0000)
    else $error("command register read non-zero");
  AST_BOOT_READ: assert property ($fell(rst_i) |-> state_q == settings_pkg::ST_IDLE
                                  ##1 ch_q == settings_pkg::SHARED_CH)
    else $error("start-up did not read shared store first");
  AST_SHARED_ONLY_WORDS: assert property (sp.wr && sp.ch == settings_pkg::SHARED_CH
                                          |-> sp.word <= settings_pkg::SHW_POWERUP && !sp.vol)
    else $error("shared store write out of range");
  AST_POWERUP_NV_ON_STORE: assert property (cmd_store && !busy && !sel_factory
                                            |-> ##[9:10] (sp.wr && sp.ch == settings_pkg::SHARED_CH))
    else $error("store did not save power-up choice");
  AST_SAVE_WORDS: assert property ($rose(wr_step) |-> sp.wr[*8])
    else $error("channel copy shorter than full set");

  COV_LOAD: cover property (cmd_load && !busy);
  COV_STORE: cover property (cmd_store && !busy && !sel_factory);
  COV_VSTORE: cover property (cmd_vstore && !busy && !sel_factory);
  COV_REFUSED: cover property ($rose(refused_q));
endmodule // camera_settings_store
`default_nettype wire

// ===== hdl/settings_pkg.sv
`default_nettype none
package settings_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int USER_CHANNELS = 15;
  localparam int SET_WORDS = 8;
  localparam int WORD_W = 32;
  localparam int WIDX_W = 3;
  localparam int CH_W = 5;
  localparam int SEL_W = 4;
  localparam int TONE_W = 10;
  localparam int TONE_DEPTH = 1024;
  localparam int SEQ_LEN_W = 4;

  // ****************************************************************
  // channel numbers and shared store layout
  // ****************************************************************
  localparam logic [CH_W-1:0] FACTORY_CH = 5'h00;
  localparam logic [CH_W-1:0] SHARED_CH = 5'h10;
  localparam logic [WIDX_W-1:0] LAST_WORD = 3'h7;
  localparam logic [WIDX_W-1:0] SHW_DEFECT_SEQ = 3'h0;
  localparam logic [WIDX_W-1:0] SHW_SLOTS = 3'h1;
  localparam logic [WIDX_W-1:0] SHW_POWERUP = 3'h2;
  localparam int DEFECT_BIT = 0;
  localparam int SEQ_EN_BIT = 1;
  localparam int SEQ_LEN_LSB = 4;
  localparam int TONE_EN_WORD = 7;
  localparam int TONE_EN_BIT = 0;
  localparam int BRIGHT_WORD = 6;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] OFS_POWERUP_CHOICE = 8'h04;
  localparam logic [7:0] OFS_LOAD_CMD = 8'h08;
  localparam logic [7:0] OFS_STORE_CMD = 8'h0C;
  localparam logic [7:0] OFS_VSTORE_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_TONE_INDEX = 8'h18;
  localparam logic [7:0] OFS_TONE_ENTRY = 8'h1C;
  localparam logic [7:0] OFS_SHARED_CTRL = 8'h20;
  localparam logic [7:0] OFS_SEQ_SLOTS = 8'h24;
  localparam logic [7:0] OFS_SETTINGS = 8'h40;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;

  // ****************************************************************
  // reset and factory values
  // ****************************************************************
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  localparam logic [TONE_W-1:0] TONE_INDEX_RESET = 10'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] FACTORY_BRIGHTNESS = 32'h0000_0064;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD_ADDR = 2'b01,
    ST_RD_DATA = 2'b10,
    ST_WR = 2'b11
  } state_t;

  typedef enum logic [1:0] {
    THEN_NONE = 2'b00,
    THEN_BOOT_LOAD = 2'b01,
    THEN_SHARED = 2'b10
  } then_t;

  function automatic logic [WORD_W-1:0] factory_word(input logic [WIDX_W-1:0] idx);
    factory_word = (idx == 3'(BRIGHT_WORD)) ? FACTORY_BRIGHTNESS : WORD_RESET;
  endfunction

  function automatic logic [WORD_W-1:0] merge_be(input logic [WORD_W-1:0] old_v,
                                                 input logic [WORD_W-1:0] new_v,
                                                 input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge_be[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    end
  endfunction
endpackage
`default_nettype wire

// ===== hdl/store_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface store_port_if;
  logic [settings_pkg::CH_W-1:0] ch;
  logic [settings_pkg::WIDX_W-1:0] word;
  logic wr;
  logic vol;
  logic [settings_pkg::WORD_W-1:0] wdata;
  logic [settings_pkg::WORD_W-1:0] rdata;
  modport ctrl (output ch, output word, output wr, output vol, output wdata, input rdata);
  modport mem (input ch, input word, input wr, input vol, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== hdl/channel_store.sv
`timescale 1ns/1ps
`default_nettype none
module channel_store (
  input wire logic core_clk_i,
  input wire logic rst_i,
  store_port_if.mem sp
);
  // ****************************************************************
  // arrays
  // ****************************************************************
  // non-volatile copies: channels 1..15 plus the shared slot 16; never reset
  logic [settings_pkg::WORD_W-1:0] nv_mem [0:16][0:settings_pkg::SET_WORDS-1];
  // quick-save copies, lost with power
  logic [settings_pkg::WORD_W-1:0] vol_mem [1:15][0:settings_pkg::SET_WORDS-1];
  logic [15:1] vol_valid_q;
  logic [settings_pkg::WORD_W-1:0] rdata_q;

  initial begin
    for (int c = 0; c <= 16; c++) begin
      for (int w = 0; w < settings_pkg::SET_WORDS; w++) begin
        nv_mem[c][w] = settings_pkg::WORD_RESET;
      end
    end
  end

  wire user_ch = (sp.ch != settings_pkg::FACTORY_CH) && (sp.ch < settings_pkg::SHARED_CH);
  wire shared_ch = (sp.ch == settings_pkg::SHARED_CH);
  wire [3:0] uch = sp.ch[3:0];
  wire use_vol = user_ch && vol_valid_q[uch];

  // ****************************************************************
  // access
  // ****************************************************************
  // channel 0 is fixed factory data and cannot be written
  // plain always: the power-on initial block also writes nv_mem
  always @(posedge core_clk_i) begin
    if (sp.wr && sp.vol && user_ch) begin
      vol_mem[uch][sp.word] <= sp.wdata;
    end
    if (sp.wr && !sp.vol && (user_ch || shared_ch)) begin
      nv_mem[sp.ch][sp.word] <= sp.wdata;
    end
  end

  // a later non-volatile save supersedes an older quick-save of that channel
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vol_valid_q <= '0;
    end else if (sp.wr && user_ch) begin
      vol_valid_q[uch] <= sp.vol;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!user_ch && !shared_ch) begin
      rdata_q <= settings_pkg::factory_word(sp.word);
    end else if (use_vol) begin
      rdata_q <= vol_mem[uch][sp.word];
    end else begin
      rdata_q <= nv_mem[sp.ch][sp.word];
    end
  end

  assign sp.rdata = rdata_q;
endmodule // channel_store
`default_nettype wire

// ===== hdl/tone_table.sv
`timescale 1ns/1ps
`default_nettype none
module tone_table #(
  parameter int DEPTH = settings_pkg::TONE_DEPTH,
  parameter int W = settings_pkg::TONE_W
) (
  input wire logic core_clk_i,
  input wire logic enable_i,
  input wire logic [W-1:0] index_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] rdata_o,
  input wire logic [W-1:0] pix_i,
  output logic [W-1:0] pix_o
);
  // contents are volatile and belong to no settings channel
  logic [W-1:0] mem [0:DEPTH-1];

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = '0;
    end
  end

  // plain always: the power-on initial block also writes mem
  always @(posedge core_clk_i) begin
    if (wr_i) begin
      mem[index_i] <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    rdata_o <= mem[index_i];
    pix_o <= enable_i ? mem[pix_i] : pix_i;
  end
endmodule // tone_table
`default_nettype wire

// ===== test/tb_camera_settings_store.sv
`timescale 1ns/1ps
`default_nettype none
module tb_camera_settings_store;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [9:0] pix = 10'h000;
  logic [31:0] rdat;
  logic [31:0] got;
  logic [9:0] pix_o;
  logic [3:0] seq_len;
  logic wreq, tone_en, defect_en, seq_en, busy;
  int errors = 0;
  int compares = 0;

  always #5 core_clk_i = ~core_clk_i;

  camera_settings_store u_camera_settings_store (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pix_i(pix),
    .pix_o(pix_o), .tone_table_enable_o(tone_en), .defect_fix_enable_o(defect_en),
    .seq_capture_enable_o(seq_en), .seq_capture_length_o(seq_len), .busy_o(busy));

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one edge before each request, so a release and a new request never share a time step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 200);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 200) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(got, exp);
  endtask

  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, settings_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end while (got[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (12) @(posedge core_clk_i);
    chk(busy, 1'b1);
    rst_i <= 1'b0;
    idle();
    chk(busy, 1'b0);
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    do_reset();
    rdchk(settings_pkg::OFS_CHANNEL_SELECT, 32'h0000_0000);
    rdchk(settings_pkg::OFS_POWERUP_CHOICE, 32'h0000_0000);
    rdchk(8'h58, 32'h0000_0064);
    rdchk(settings_pkg::OFS_VSTORE_CMD, 32'h0000_0000);
    chk(tone_en, 1'b0);
    bus(1'b1, settings_pkg::OFS_STORE_CMD, 32'h0000_0001);
    idle();
    rdchk(settings_pkg::OFS_STATUS, 32'h0000_0002);
    $display("test reset and refusal done");
    bus(1'b1, settings_pkg::OFS_CHANNEL_SELECT, 32'h0000_0003);
    rdchk(settings_pkg::OFS_CHANNEL_SELECT, 32'h0000_0003);
    rdchk(settings_pkg::OFS_LOAD_CMD, 32'h0000_0000);
    bus(1'b1, settings_pkg::OFS_SETTINGS, 32'h1234_5678);
    bus(1'b1, settings_pkg::OFS_SHARED_CTRL, 32'h0000_0031);
    bus(1'b1, settings_pkg::OFS_SEQ_SLOTS, 32'h8765_4321);
    bus(1'b1, settings_pkg::OFS_STORE_CMD, 32'h0000_0001);
    bus(1'b1, settings_pkg::OFS_SETTINGS, 32'hdead_0001);
    bus(1'b1, settings_pkg::OFS_LOAD_CMD, 32'h0000_0001);
    idle();
    rdchk(settings_pkg::OFS_SETTINGS, 32'h1234_5678);
    rdchk(settings_pkg::OFS_STATUS, 32'h0000_0000);
    bus(1'b1, settings_pkg::OFS_SETTINGS, 32'h0c0c_0c0c);
    bus(1'b1, settings_pkg::OFS_VSTORE_CMD, 32'h0000_0001);
    bus(1'b1, settings_pkg::OFS_SETTINGS, 32'hdead_0002);
    bus(1'b1, settings_pkg::OFS_LOAD_CMD, 32'h0000_0001);
    idle();
    rdchk(settings_pkg::OFS_SETTINGS, 32'h0c0c_0c0c);
    $display("test load and store done");
    bus(1'b1, settings_pkg::OFS_TONE_INDEX, 32'h0000_03ff);
    bus(1'b1, settings_pkg::OFS_TONE_ENTRY, 32'h0000_0155);
    rdchk(settings_pkg::OFS_TONE_ENTRY, 32'h0000_0155);
    bus(1'b1, 8'h5c, 32'h0000_0001);
    pix <= 10'h3ff;
    repeat (3) @(posedge core_clk_i);
    chk(pix_o, 10'h155);
    chk(tone_en, 1'b1);
    $display("test tone table done");
    bus(1'b1, settings_pkg::OFS_POWERUP_CHOICE, 32'h0000_0003);
    bus(1'b1, settings_pkg::OFS_STORE_CMD, 32'h0000_0001);
    bus(1'b1, settings_pkg::OFS_SETTINGS, 32'hdead_0003);
    bus(1'b1, settings_pkg::OFS_SHARED_CTRL, 32'h0000_0000);
    bus(1'b1, settings_pkg::OFS_SEQ_SLOTS, 32'h0000_0000);
    do_reset();
    rdchk(settings_pkg::OFS_SEQ_SLOTS, 32'h8765_4321);
    rdchk(settings_pkg::OFS_POWERUP_CHOICE, 32'h0000_0003);
    rdchk(settings_pkg::OFS_SETTINGS, 32'h0c0c_0c0c);
    rdchk(settings_pkg::OFS_CHANNEL_SELECT, 32'h0000_0000);
    chk({defect_en, seq_en, seq_len}, 6'h23);
    chk(tone_en, 1'b1);
    $display("test start-up restore done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    end_of_test();
  end
endmodule // tb_camera_settings_store
`default_nettype wire
